// ==== src/pmcal_pkg.sv ====
// Package: command codes, field positions, reset values for the block
package pmcal_pkg;

   // ======================================================
   // Command codes
   localparam logic [7:0] PMCAL_CMD_VOUT_OFS = 8'hD2;
   localparam logic [7:0] PMCAL_CMD_VIN_GAIN = 8'hD3;
   localparam logic [7:0] PMCAL_CMD_VIN_OFS = 8'hD4;
   localparam logic [7:0] PMCAL_CMD_IOUT_GAIN = 8'hD6;
   localparam logic [7:0] PMCAL_CMD_IOUT_OFS = 8'hD7;
   localparam logic [7:0] PMCAL_CMD_FW_REV = 8'hDB;
   localparam logic [7:0] PMCAL_CMD_PIN_CFG = 8'hE0;
   localparam logic [7:0] PMCAL_CMD_ONOFF = 8'hE1;
   localparam logic [7:0] PMCAL_CMD_PG_POL = 8'hE2;
   localparam logic [7:0] PMCAL_CMD_ID_BLOCK = 8'hF0;

   // ======================================================
   // Linear format exponent field and required exponents
   localparam int PMCAL_EXP_MSB = 15;
   localparam int PMCAL_EXP_LSB = 11;
   localparam logic [4:0] PMCAL_EXP_VOUT_OFS = 5'h14;
   localparam logic [4:0] PMCAL_EXP_VIN_OFS = 5'h1D;
   localparam logic [4:0] PMCAL_EXP_IOUT_OFS = 5'h1C;

   // ======================================================
   // Gain limits
   localparam logic [15:0] PMCAL_GAIN_MIN = 16'h1999;
   localparam logic [15:0] PMCAL_GAIN_MAX = 16'h2666;

   // ======================================================
   // Field positions
   localparam int PMCAL_ARA_BIT = 4;
   localparam int PMCAL_MAP_MSB = 3;
   localparam int PMCAL_AND_BIT = 1;
   localparam int PMCAL_SEC_POL_BIT = 0;
   localparam int PMCAL_PG_POL_BIT = 0;

   // ======================================================
   // Pin map codes
   localparam logic [3:0] PMCAL_MAP_SEC_PG = 4'h0;
   localparam logic [3:0] PMCAL_MAP_TRIM_PG = 4'h1;
   localparam logic [3:0] PMCAL_MAP_TRIM_SEC = 4'h2;

   // ======================================================
   // Reset values and sizes
   localparam logic [15:0] PMCAL_RST_VIN_GAIN = 16'h2000;
   localparam logic [4:0] PMCAL_RST_PIN_CFG = 5'h00;
   localparam logic [1:0] PMCAL_RST_ONOFF = 2'h0;
   localparam logic PMCAL_RST_PG_POL = 1'b1;
   localparam int PMCAL_ID_BYTES = 12;
   localparam logic [3:0] PMCAL_ID_LAST = 4'hB;

endpackage : pmcal_pkg

// ==== src/pmcal_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps

module pmcal_sync
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // Data
   input wire logic i_async,
   output logic o_sync
);

   logic meta_reg;

   // ======================================================
   // Two stages, first read only by the second
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_reg <= 1'b0;
         o_sync <= 1'b0;
      end
      else if (i_clk_en)
      begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end

endmodule : pmcal_sync

// ==== src/pmcal_top.sv ====
// Maker calibration, pin mapping and identification command bank
`timescale 1ns/100ps

module pmcal_top
#(
   parameter logic [15:0] VOUT_OFS_INIT = 16'hA000,
   parameter logic [15:0] VIN_OFS_INIT = 16'hE800,
   parameter logic [15:0] IOUT_GAIN_INIT = 16'h2000,
   parameter logic [15:0] IOUT_OFS_INIT = 16'hE000,
   // Arbitrary value
   parameter logic [7:0] FW_REVISION = 8'h10
)
(
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // Command port from the bus protocol engine
   input wire logic i_wr_valid,
   input wire logic i_rd_valid,
   input wire logic [7:0] i_cmd,
   input wire logic [15:0] i_wdata,
   input wire logic [3:0] i_blk_idx,
   output logic [15:0] o_rdata,
   output logic o_rvalid,
   output logic o_wr_done,
   output logic o_invalid_data,
   output logic o_invalid_cmd,
   // Device-type write protect and options
   input wire logic i_write_protect_bit,
   input wire logic i_load_share_option,
   // Nonvolatile storage
   input wire logic i_nv_load_valid,
   input wire logic [7:0] i_nv_load_cmd,
   input wire logic [15:0] i_nv_load_data,
   output logic o_nv_store,
   output logic [7:0] o_nv_cmd,
   output logic [15:0] o_nv_data,
   // Alert address handling
   input wire logic i_alert_active,
   output logic o_answer_own_addr,
   output logic o_answer_ara,
   // Multipurpose pins and on/off
   input wire logic i_first_multipurpose_pin,
   input wire logic i_second_multipurpose_pin,
   output logic o_second_multipurpose_pin,
   output logic o_second_multipurpose_pin_oe,
   output logic o_trim_select,
   input wire logic i_primary_on,
   input wire logic i_power_is_good,
   output logic o_output_on,
   // Calibration factors for the converter
   output logic [15:0] o_vout_ofs_cal,
   output logic [15:0] o_vin_gain_cal,
   output logic [15:0] o_vin_ofs_cal,
   output logic [15:0] o_iout_gain_cal,
   output logic [15:0] o_iout_ofs_cal
);

   // ======================================================
   // Functions
   function automatic logic gain_ok(input logic [15:0] w);
      gain_ok = (w >= pmcal_pkg::PMCAL_GAIN_MIN) &&
         (w <= pmcal_pkg::PMCAL_GAIN_MAX);
   endfunction : gain_ok

   function automatic logic exp_ok(input logic [15:0] w,
      input logic [4:0] e);
      exp_ok = (w[pmcal_pkg::PMCAL_EXP_MSB:pmcal_pkg::PMCAL_EXP_LSB] == e);
   endfunction : exp_ok

   // ======================================================
   // Declarations
   logic [15:0] vout_ofs_reg;
   logic [15:0] vin_gain_reg;
   logic [15:0] vin_ofs_reg;
   logic [15:0] iout_gain_reg;
   logic [15:0] iout_ofs_reg;
   logic [4:0] pin_cfg_reg;
   logic [1:0] onoff_reg;
   logic pg_pol_reg;
   logic [7:0] id_mem_reg [0:pmcal_pkg::PMCAL_ID_BYTES-1];
   logic pin1_sync;
   logic pin2_sync;
   logic is_vout_ofs;
   logic is_vin_gain;
   logic is_vin_ofs;
   logic is_iout_gain;
   logic is_iout_ofs;
   logic is_fw;
   logic is_pin_cfg;
   logic is_onoff;
   logic is_pg_pol;
   logic is_id;
   logic known_cmd;
   logic idx_ok;
   logic map_ok;
   logic data_ok;
   logic wr_protected;
   logic wr_accept;
   logic wr_reject;
   logic nv_cmd;
   logic [15:0] rd_mux;
   logic [3:0] map;
   logic sec_from_pin1;
   logic sec_from_pin2;
   logic sec_level;
   logic sec_enable;
   logic on_next;
   logic pg_drive;

   // ======================================================
   // Pin synchronisers
   pmcal_sync u_sync_pin1
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_clk_en(i_clk_en),
      .i_async(i_first_multipurpose_pin),
      .o_sync(pin1_sync)
   );

   pmcal_sync u_sync_pin2
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_clk_en(i_clk_en),
      .i_async(i_second_multipurpose_pin),
      .o_sync(pin2_sync)
   );

   // ======================================================
   // Command decode
   assign is_vout_ofs = (i_cmd == pmcal_pkg::PMCAL_CMD_VOUT_OFS);
   assign is_vin_gain = (i_cmd == pmcal_pkg::PMCAL_CMD_VIN_GAIN);
   assign is_vin_ofs = (i_cmd == pmcal_pkg::PMCAL_CMD_VIN_OFS);
   assign is_iout_gain = (i_cmd == pmcal_pkg::PMCAL_CMD_IOUT_GAIN);
   assign is_iout_ofs = (i_cmd == pmcal_pkg::PMCAL_CMD_IOUT_OFS);
   assign is_fw = (i_cmd == pmcal_pkg::PMCAL_CMD_FW_REV);
   assign is_pin_cfg = (i_cmd == pmcal_pkg::PMCAL_CMD_PIN_CFG);
   assign is_onoff = (i_cmd == pmcal_pkg::PMCAL_CMD_ONOFF);
   assign is_pg_pol = (i_cmd == pmcal_pkg::PMCAL_CMD_PG_POL);
   assign is_id = (i_cmd == pmcal_pkg::PMCAL_CMD_ID_BLOCK);
   assign known_cmd = is_vout_ofs | is_vin_gain | is_vin_ofs |
      is_iout_gain | is_iout_ofs | is_fw | is_pin_cfg | is_onoff |
      is_pg_pol | is_id;
   assign idx_ok = (i_blk_idx <= pmcal_pkg::PMCAL_ID_LAST);

   // ======================================================
   // Write checks
   assign map_ok = i_load_share_option ?
      (i_wdata[3:0] == pmcal_pkg::PMCAL_MAP_SEC_PG) :
      ((i_wdata[3:0] == pmcal_pkg::PMCAL_MAP_SEC_PG) ||
       (i_wdata[3:0] == pmcal_pkg::PMCAL_MAP_TRIM_PG) ||
       (i_wdata[3:0] == pmcal_pkg::PMCAL_MAP_TRIM_SEC));
   // Write protect active high
   assign wr_protected = i_write_protect_bit &
      (is_vout_ofs | is_vin_gain | is_vin_ofs | is_iout_gain |
       is_iout_ofs | is_id);
   assign data_ok =
      (is_vout_ofs & exp_ok(i_wdata, pmcal_pkg::PMCAL_EXP_VOUT_OFS)) |
      (is_vin_ofs & exp_ok(i_wdata, pmcal_pkg::PMCAL_EXP_VIN_OFS)) |
      (is_iout_ofs & exp_ok(i_wdata, pmcal_pkg::PMCAL_EXP_IOUT_OFS)) |
      ((is_vin_gain | is_iout_gain) & gain_ok(i_wdata)) |
      (is_pin_cfg & map_ok) |
      is_onoff | is_pg_pol | (is_id & idx_ok);
   assign wr_accept = i_wr_valid & data_ok & ~wr_protected;
   // Firmware revision is read only
   assign wr_reject = i_wr_valid & known_cmd & ~wr_accept;
   assign nv_cmd = is_vout_ofs | is_vin_gain | is_vin_ofs;

   // ======================================================
   // Calibration registers
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         vout_ofs_reg <= VOUT_OFS_INIT;
         vin_gain_reg <= pmcal_pkg::PMCAL_RST_VIN_GAIN;
         vin_ofs_reg <= VIN_OFS_INIT;
         iout_gain_reg <= IOUT_GAIN_INIT;
         iout_ofs_reg <= IOUT_OFS_INIT;
      end
      else if (i_clk_en)
      begin
         // Restore from storage after power up
         if (i_nv_load_valid)
         begin
            if (i_nv_load_cmd == pmcal_pkg::PMCAL_CMD_VOUT_OFS)
               vout_ofs_reg <= i_nv_load_data;
            if (i_nv_load_cmd == pmcal_pkg::PMCAL_CMD_VIN_GAIN)
               vin_gain_reg <= i_nv_load_data;
            if (i_nv_load_cmd == pmcal_pkg::PMCAL_CMD_VIN_OFS)
               vin_ofs_reg <= i_nv_load_data;
         end
         else if (wr_accept)
         begin
            if (is_vout_ofs)
               vout_ofs_reg <= i_wdata;
            if (is_vin_gain)
               vin_gain_reg <= i_wdata;
            if (is_vin_ofs)
               vin_ofs_reg <= i_wdata;
            if (is_iout_gain)
               iout_gain_reg <= i_wdata;
            if (is_iout_ofs)
               iout_ofs_reg <= i_wdata;
         end
      end
   end

   // ======================================================
   // Configuration registers, writable bits only
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_cfg_reg <= pmcal_pkg::PMCAL_RST_PIN_CFG;
         onoff_reg <= pmcal_pkg::PMCAL_RST_ONOFF;
         pg_pol_reg <= pmcal_pkg::PMCAL_RST_PG_POL;
      end
      else if (i_clk_en && wr_accept)
      begin
         if (is_pin_cfg)
            pin_cfg_reg <= i_wdata[4:0];
         if (is_onoff)
            onoff_reg <= i_wdata[1:0];
         if (is_pg_pol)
            pg_pol_reg <= i_wdata[pmcal_pkg::PMCAL_PG_POL_BIT];
      end
   end

   // ======================================================
   // Identification block, one byte per access
   always_ff @(posedge i_clock)
   begin
      if (i_clk_en && wr_accept && is_id)
         id_mem_reg[i_blk_idx] <= i_wdata[7:0];
   end

   // ======================================================
   // Read mux, reserved bits zero
   assign rd_mux =
      is_vout_ofs ? vout_ofs_reg :
      is_vin_gain ? vin_gain_reg :
      is_vin_ofs ? vin_ofs_reg :
      is_iout_gain ? iout_gain_reg :
      is_iout_ofs ? iout_ofs_reg :
      is_fw ? {8'h00, FW_REVISION} :
      is_pin_cfg ? {11'h000, pin_cfg_reg} :
      is_onoff ? {14'h0000, onoff_reg} :
      is_pg_pol ? {15'h0000, pg_pol_reg} :
      (is_id && idx_ok) ? {8'h00, id_mem_reg[i_blk_idx]} :
      16'h0000;

   // ======================================================
   // Answers, flags and storage requests
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata <= 16'h0000;
         o_rvalid <= 1'b0;
         o_wr_done <= 1'b0;
         o_invalid_data <= 1'b0;
         o_invalid_cmd <= 1'b0;
         o_nv_store <= 1'b0;
         o_nv_cmd <= 8'h00;
         o_nv_data <= 16'h0000;
      end
      else if (i_clk_en)
      begin
         o_rvalid <= i_rd_valid & known_cmd & (~is_id | idx_ok);
         if (i_rd_valid)
            o_rdata <= rd_mux;
         o_wr_done <= wr_accept;
         o_invalid_data <= wr_reject |
            (i_rd_valid & is_id & ~idx_ok);
         o_invalid_cmd <= (i_wr_valid | i_rd_valid) & ~known_cmd;
         o_nv_store <= wr_accept & nv_cmd;
         if (wr_accept && nv_cmd)
         begin
            o_nv_cmd <= i_cmd;
            o_nv_data <= i_wdata;
         end
      end
   end

   // ======================================================
   // Pin function selection
   assign map = pin_cfg_reg[pmcal_pkg::PMCAL_MAP_MSB:0];
   assign sec_from_pin1 = (map == pmcal_pkg::PMCAL_MAP_SEC_PG);
   assign sec_from_pin2 = (map == pmcal_pkg::PMCAL_MAP_TRIM_SEC);
   assign sec_level = sec_from_pin1 ? pin1_sync : pin2_sync;
   // Low or high enable per polarity bit
   assign sec_enable = onoff_reg[pmcal_pkg::PMCAL_SEC_POL_BIT] ?
      sec_level : ~sec_level;
   assign on_next = i_primary_on &
      (~onoff_reg[pmcal_pkg::PMCAL_AND_BIT] |
       ~(sec_from_pin1 | sec_from_pin2) | sec_enable);
   assign pg_drive = pg_pol_reg ? i_power_is_good :
      ~i_power_is_good;

   // ======================================================
   // Pin and address outputs
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_output_on <= 1'b0;
         o_second_multipurpose_pin <= 1'b0;
         o_second_multipurpose_pin_oe <= 1'b0;
         o_trim_select <= 1'b0;
         o_answer_own_addr <= 1'b1;
         o_answer_ara <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_output_on <= on_next;
         o_second_multipurpose_pin <= pg_drive;
         o_second_multipurpose_pin_oe <= ~sec_from_pin2;
         o_trim_select <= (map == pmcal_pkg::PMCAL_MAP_TRIM_PG) |
            sec_from_pin2;
         o_answer_own_addr <= ~i_alert_active |
            ~pin_cfg_reg[pmcal_pkg::PMCAL_ARA_BIT];
         o_answer_ara <= i_alert_active &
            pin_cfg_reg[pmcal_pkg::PMCAL_ARA_BIT];
      end
   end

   // ======================================================
   // Calibration factor outputs
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_vout_ofs_cal <= VOUT_OFS_INIT;
         o_vin_gain_cal <= pmcal_pkg::PMCAL_RST_VIN_GAIN;
         o_vin_ofs_cal <= VIN_OFS_INIT;
         o_iout_gain_cal <= IOUT_GAIN_INIT;
         o_iout_ofs_cal <= IOUT_OFS_INIT;
      end
      else if (i_clk_en)
      begin
         o_vout_ofs_cal <= vout_ofs_reg;
         o_vin_gain_cal <= vin_gain_reg;
         o_vin_ofs_cal <= vin_ofs_reg;
         o_iout_gain_cal <= iout_gain_reg;
         o_iout_ofs_cal <= iout_ofs_reg;
      end
   end

endmodule : pmcal_top

// ==== verification/pmcal_host.sv ====
// Host model driving the command port one access at a time
`timescale 1ns/100ps

module pmcal_host
(
   // Clock
   input wire logic i_clock,
   // Requests
   output logic o_wr_valid,
   output logic o_rd_valid,
   output logic [7:0] o_cmd,
   output logic [15:0] o_wdata,
   output logic [3:0] o_blk_idx,
   // Answers
   input wire logic [15:0] i_rdata,
   input wire logic i_rvalid,
   input wire logic i_wr_done,
   input wire logic i_invalid_data,
   input wire logic i_invalid_cmd
);
   logic [3:0] got_fl;
   logic [15:0] got_rd;

   initial
   begin
      o_wr_valid = 1'b0;
      o_rd_valid = 1'b0;
      o_cmd = 8'h00;
      o_wdata = 16'h0000;
      o_blk_idx = 4'h0;
   end

   // One word or one block byte, answer sampled a cycle later
   task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, input logic [3:0] x);
      @(negedge i_clock);
      o_wr_valid = w;
      o_rd_valid = !w;
      o_cmd = c;
      o_wdata = d;
      o_blk_idx = x;
      @(negedge i_clock);
      got_fl = {i_wr_done, i_rvalid, i_invalid_data, i_invalid_cmd};
      got_rd = i_rdata;
      o_wr_valid = 1'b0;
      o_rd_valid = 1'b0;
      // Released lines show the inverse, not stale data
      o_cmd = ~c;
      o_wdata = ~d;
      o_blk_idx = ~x;
   endtask : xfer
endmodule : pmcal_host

// ==== verification/pmcal_top_asserts.sv ====
// Checker for the command answers, address choice and output gating
`timescale 1ns/100ps

module pmcal_top_asserts
#(
   parameter logic [7:0] FW_REVISION = 8'h10
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // Command port
   input wire logic i_wr_valid,
   input wire logic i_rd_valid,
   input wire logic [7:0] i_cmd,
   input wire logic [15:0] i_wdata,
   input wire logic [15:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic o_wr_done,
   input wire logic o_invalid_data,
   // Protection, storage, address, on/off
   input wire logic i_write_protect_bit,
   input wire logic o_nv_store,
   input wire logic [15:0] o_nv_data,
   input wire logic i_alert_active,
   input wire logic o_answer_own_addr,
   input wire logic o_answer_ara,
   input wire logic i_primary_on,
   input wire logic o_output_on
);
   // ==========================================
   // Helpers
   wire logic wr_on = i_wr_valid && i_clk_en && !i_write_protect_bit;
   wire logic rd_on = i_rd_valid && i_clk_en;
   wire logic [4:0] ex = i_wdata[15:11];
   wire logic gain_ok = i_wdata >= 16'h1999 && i_wdata <= 16'h2666;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   // ==========================================
   // Assertions
   chk_fw_readonly: assert property (
      wr_on && i_cmd == 8'hDB |=> o_invalid_data && !o_wr_done)
      else $error("revision write accepted");
   chk_wp_lockout: assert property (
      i_wr_valid && i_clk_en && i_write_protect_bit && i_cmd == 8'hF0
      |=> o_invalid_data && !o_wr_done)
      else $error("protected write accepted");
   chk_gain_range: assert property (
      wr_on && (i_cmd == 8'hD3 || i_cmd == 8'hD6) && !gain_ok
      |=> o_invalid_data && !o_wr_done)
      else $error("gain out of range accepted");
   chk_vout_exp: assert property (
      wr_on && i_cmd == 8'hD2 && ex != 5'h14 |=> o_invalid_data)
      else $error("vout offset exponent accepted");
   chk_vin_exp: assert property (
      wr_on && i_cmd == 8'hD4 && ex != 5'h1D |=> o_invalid_data)
      else $error("vin offset exponent accepted");
   chk_iout_exp: assert property (
      wr_on && i_cmd == 8'hD7 && ex != 5'h1C |=> o_invalid_data)
      else $error("iout offset exponent accepted");
   chk_nv_store: assert property (
      wr_on && i_cmd == 8'hD3 && gain_ok
      |=> o_wr_done && o_nv_store && o_nv_data == $past(i_wdata))
      else $error("gain not stored");
   chk_ara_excl: assert property (
      o_answer_ara |-> !o_answer_own_addr)
      else $error("both addresses answered");
   chk_own_addr: assert property (
      $past(i_clk_en) && !$past(i_alert_active) |-> o_answer_own_addr)
      else $error("own address dropped");
   chk_fw_read: assert property (
      rd_on && i_cmd == 8'hDB |=> o_rvalid && o_rdata == {8'h00, FW_REVISION})
      else $error("revision read wrong");
   chk_resv_zero: assert property (
      rd_on && i_cmd == 8'hE1 |=> o_rvalid && o_rdata[15:2] == 14'h0000)
      else $error("reserved bits not zero");
   chk_off_gate: assert property (
      (!i_primary_on && i_clk_en) [*3] |=> !o_output_on)
      else $error("output on without primary");

   cover property (wr_on && i_cmd == 8'hD3 ##1 o_wr_done);
   cover property (o_answer_ara);
   cover property (o_output_on);
endmodule : pmcal_top_asserts

bind pmcal_top pmcal_top_asserts #(.FW_REVISION(FW_REVISION)) u_chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
   .i_wr_valid(i_wr_valid), .i_rd_valid(i_rd_valid), .i_cmd(i_cmd),
   .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
   .o_wr_done(o_wr_done), .o_invalid_data(o_invalid_data),
   .i_write_protect_bit(i_write_protect_bit), .o_nv_store(o_nv_store),
   .o_nv_data(o_nv_data), .i_alert_active(i_alert_active),
   .o_answer_own_addr(o_answer_own_addr), .o_answer_ara(o_answer_ara),
   .i_primary_on(i_primary_on), .o_output_on(o_output_on)
);

// ==== verification/pmcal_top_tb_top.sv ====
// Testbench for the calibration and pin configuration bank
`timescale 1ns/100ps

module pmcal_top_tb_top;
   typedef struct {
      logic w;
      logic [7:0] c;
      logic [15:0] d;
      logic [3:0] x;
      logic [3:0] f;
      logic [15:0] r;
   } pmcal_row_t;

   logic i_clock, rst, prot, ls, alert, pin1, p2d, prim, good;
   logic wv, rv, rvl, wdn, ivd, ivc, own, ara, p2o, oe, trim, on;
   logic [7:0] cmd;
   logic [15:0] wd, rd;
   logic [3:0] bi;
   logic en, nvv;
   logic [7:0] nvc;
   logic [15:0] nvd;
   wire logic [7:0] nvo;
   wire logic [79:0] cal;
   int err_total = 0;
   int total_checks = 0;
   wire logic pin2 = oe ? p2o : p2d;
   wire logic [3:0] pv = {on, oe, trim, p2o};
   // Flags: 8 done, 4 read valid, 2 bad data, 1 bad command
   pmcal_row_t rows [0:33] = '{
      '{0,8'hD3,0,0,4'h4,16'h2000}, '{1,8'hD3,16'h2666,0,4'h8,0},
      '{0,8'hD3,0,0,4'h4,16'h2666}, '{1,8'hD3,16'h2667,0,4'h2,0},
      '{1,8'hD6,16'h1998,0,4'h2,0}, '{1,8'hD6,16'h1999,0,4'h8,0},
      '{0,8'hD6,0,0,4'h4,16'h1999}, '{1,8'hD2,16'hA123,0,4'h8,0},
      '{1,8'hD2,16'hA923,0,4'h2,0}, '{0,8'hD2,0,0,4'h4,16'hA123},
      '{1,8'hD4,16'hE805,0,4'h8,0}, '{1,8'hD4,16'hE005,0,4'h2,0},
      '{0,8'hD4,0,0,4'h4,16'hE805}, '{1,8'hD7,16'hE007,0,4'h8,0},
      '{1,8'hD7,16'hE807,0,4'h2,0}, '{0,8'hDB,0,0,4'h4,16'h0010},
      '{1,8'hDB,16'h0011,0,4'h2,0}, '{0,8'hE0,0,0,4'h4,0},
      '{0,8'hE1,0,0,4'h4,0}, '{0,8'hE2,0,0,4'h4,16'h0001},
      '{1,8'hE2,16'h00FE,0,4'h8,0}, '{0,8'hE2,0,0,4'h4,0},
      '{1,8'hE1,16'hFFFF,0,4'h8,0}, '{0,8'hE1,0,0,4'h4,16'h0003},
      '{1,8'hE0,16'h0003,0,4'h2,0}, '{1,8'hE0,16'h00F1,0,4'h8,0},
      '{0,8'hE0,0,0,4'h4,16'h0011}, '{1,8'hE0,16'h0010,0,4'h8,0},
      '{1,8'hF0,16'h00A5,0,4'h8,0}, '{1,8'hF0,16'h005A,4'hB,4'h8,0},
      '{0,8'hF0,0,0,4'h4,16'h00A5}, '{0,8'hF0,0,4'hB,4'h4,16'h005A},
      '{1,8'hF0,16'h0001,4'hC,4'h2,0}, '{0,8'h55,0,0,4'h1,0}};

   pmcal_host i_pmcal_host (.i_clock(i_clock), .o_wr_valid(wv),
      .o_rd_valid(rv), .o_cmd(cmd), .o_wdata(wd), .o_blk_idx(bi),
      .i_rdata(rd), .i_rvalid(rvl), .i_wr_done(wdn),
      .i_invalid_data(ivd), .i_invalid_cmd(ivc));

   pmcal_top i_pmcal_top (.i_clock(i_clock), .i_rst(rst),
      .i_clk_en(en), .i_wr_valid(wv), .i_rd_valid(rv), .i_cmd(cmd),
      .i_wdata(wd), .i_blk_idx(bi), .o_rdata(rd), .o_rvalid(rvl),
      .o_wr_done(wdn), .o_invalid_data(ivd), .o_invalid_cmd(ivc),
      .i_write_protect_bit(prot), .i_load_share_option(ls),
      .i_nv_load_valid(nvv), .i_nv_load_cmd(nvc),
      .i_nv_load_data(nvd), .o_nv_store(), .o_nv_cmd(nvo),
      .o_nv_data(), .i_alert_active(alert), .o_answer_own_addr(own),
      .o_answer_ara(ara), .i_first_multipurpose_pin(pin1),
      .i_second_multipurpose_pin(pin2), .o_second_multipurpose_pin(p2o),
      .o_second_multipurpose_pin_oe(oe), .o_trim_select(trim),
      .i_primary_on(prim), .i_power_is_good(good), .o_output_on(on),
      .o_vout_ofs_cal(cal[79:64]), .o_vin_gain_cal(cal[63:48]),
      .o_vin_ofs_cal(cal[47:32]), .o_iout_gain_cal(cal[31:16]),
      .o_iout_ofs_cal(cal[15:0]));

   initial
   begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic op(input logic w, input logic [7:0] c,
      input logic [15:0] d, input logic [3:0] x, input logic [3:0] f,
      input logic [15:0] r);
      i_pmcal_host.xfer(w, c, d, x);
      chk({12'h000, i_pmcal_host.got_fl}, {12'h000, f});
      if (f[2])
         chk(i_pmcal_host.got_rd, r);
   endtask : op

   task automatic pins(input logic [3:0] e);
      repeat (4) @(negedge i_clock);
      chk({12'h000, pv}, {12'h000, e});
   endtask : pins

   task automatic results;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   initial
   begin
      repeat (5000) @(posedge i_clock);
      err_total++;
      results();
   end

   initial
   begin
      {rst, prot, ls, alert, pin1, p2d, prim, good} = 8'h80;
      en = 1'b1;
      {nvv, nvc, nvd} = 25'h0000000;
      repeat (2) @(negedge i_clock);
      rst = 1'b0;
      foreach (rows[k])
         op(rows[k].w, rows[k].c, rows[k].d, rows[k].x, rows[k].f,
            rows[k].r);
      $display("test table done");
      prot = 1'b1;
      op(1, 8'hD3, 16'h2100, 0, 4'h2, 0);
      op(1, 8'hF0, 16'h0077, 0, 4'h2, 0);
      op(1, 8'hE2, 16'h0000, 0, 4'h8, 0);
      op(0, 8'hD3, 0, 0, 4'h4, 16'h2666);
      prot = 1'b0;
      $display("test protect done");
      alert = 1'b1;
      repeat (2) @(negedge i_clock);
      chk({14'h0000, own, ara}, 16'h0001);
      op(1, 8'hE0, 16'h0000, 0, 4'h8, 0);
      repeat (2) @(negedge i_clock);
      chk({14'h0000, own, ara}, 16'h0002);
      alert = 1'b0;
      $display("test alert done");
      {prim, good, pin1} = 3'h7;
      pins(4'hC);
      pin1 = 1'b0;
      pins(4'h4);
      op(1, 8'hE1, 16'h0002, 0, 4'h8, 0);
      pins(4'hC);
      op(1, 8'hE1, 16'h0000, 0, 4'h8, 0);
      pin1 = 1'b1;
      pins(4'hC);
      op(1, 8'hE2, 16'h0001, 0, 4'h8, 0);
      pins(4'hD);
      op(1, 8'hE0, 16'h0002, 0, 4'h8, 0);
      op(1, 8'hE1, 16'h0003, 0, 4'h8, 0);
      pins(4'h3);
      p2d = 1'b1;
      pins(4'hB);
      prim = 1'b0;
      pins(4'h3);
      op(1, 8'hE0, 16'h0001, 0, 4'h8, 0);
      pins(4'h7);
      prim = 1'b1;
      pins(4'hF);
      $display("test pins done");
      ls = 1'b1;
      op(1, 8'hE0, 16'h0002, 0, 4'h2, 0);
      op(1, 8'hE0, 16'h0000, 0, 4'h8, 0);
      ls = 1'b0;
      rst = 1'b1;
      @(negedge i_clock);
      rst = 1'b0;
      op(0, 8'hE2, 0, 0, 4'h4, 16'h0001);
      op(0, 8'hD3, 0, 0, 4'h4, 16'h2000);
      // Restore a factor from storage, then store a new one
      {nvv, nvc, nvd} = {1'b1, 8'hD3, 16'h2123};
      @(negedge i_clock);
      nvv = 1'b0;
      op(0, 8'hD3, 0, 0, 4'h4, 16'h2123);
      op(1, 8'hD4, 16'hE801, 0, 4'h8, 0);
      chk({8'h00, nvo}, 16'h00D4);
      @(negedge i_clock);
      chk(cal[79:64], 16'hA000);
      chk(cal[63:48], 16'h2123);
      chk(cal[47:32], 16'hE801);
      chk(cal[31:16], 16'h2000);
      chk(cal[15:0], 16'hE000);
      $display("test reset done");
      // Enable low: request ignored, flags and registers frozen
      en = 1'b0;
      op(1, 8'hE2, 16'h0000, 0, 4'h0, 0);
      en = 1'b1;
      op(0, 8'hE2, 0, 0, 4'h4, 16'h0001);
      $display("test enable done");
      results();
   end
endmodule : pmcal_top_tb_top
